// ---- hw/sfcx_pkg.sv ----
// Constants, codes and types of the float command exchange slot.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package sfcx_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_RESPONSE = 8'h00;
    localparam logic [7:0] ADDR_VALUE_A = 8'h04;
    localparam logic [7:0] ADDR_VALUE_B = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_COMMAND = 8'h10;
    localparam logic [7:0] ADDR_OPERAND_A = 8'h14;
    localparam logic [7:0] ADDR_OPERAND_B = 8'h18;

    // AXI responses
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Response word fields
    localparam int unsigned TAG_W = 5;
    localparam int unsigned RESP_TAG_LSB = 8;
    localparam int unsigned RESP_INTEG_BIT = 13;
    localparam int unsigned RESP_ACK_LSB = 14;
    localparam logic [7:0] RESP_RESERVED = 8'h00;

    // Status word fields
    localparam int unsigned STAT_TARGET1_BIT = 0;
    localparam int unsigned STAT_COMP1_BIT = 1;
    localparam int unsigned STAT_TARGET2_BIT = 2;
    localparam int unsigned STAT_COMP2_BIT = 3;
    localparam int unsigned STAT_TARGET3_BIT = 4;
    localparam int unsigned STAT_ONE_BIT = 5;
    localparam int unsigned STAT_SCRIPT_LSB = 6;
    localparam int unsigned STAT_ENTER_BIT = 8;
    localparam int unsigned STAT_INPUT_LSB = 9;
    localparam int unsigned STAT_MOTION_BIT = 12;
    localparam int unsigned STAT_NET_BIT = 13;
    localparam int unsigned STAT_INTEG_BIT = 14;
    localparam int unsigned STAT_VALID_BIT = 15;

    // Acknowledge sequence
    localparam logic [1:0] ACK_IDLE = 2'h0;
    localparam logic [1:0] ACK_FIRST = 2'h1;
    localparam logic [1:0] ACK_LAST = 2'h3;

    // Command codes; grouped codes carry the tag in bits 4:0
    localparam logic [15:0] CMD_NONE = 16'h0000;
    localparam logic [15:0] CMD_NEXT_A = 16'h0001;
    localparam logic [15:0] CMD_NEXT_B = 16'h0002;
    localparam logic [15:0] CMD_AUTO = 16'h0003;
    localparam logic [15:0] CMD_ROT_CLEAR = 16'h0004;
    localparam logic [10:0] GRP_REPORT = 11'h001;
    localparam logic [10:0] GRP_ADD = 11'h002;
    localparam logic [10:0] GRP_LOAD = 11'h003;

    // Returned value tags
    localparam logic [4:0] TAG_GROSS = 5'h00;
    localparam logic [4:0] TAG_NET = 5'h01;
    localparam logic [4:0] TAG_FINE_GROSS = 5'h03;
    localparam logic [4:0] TAG_FINE_NET = 5'h04;
    localparam logic [4:0] TAG_RATE = 5'h06;
    localparam logic [4:0] TAG_LAST_DATA = 5'h1D;
    localparam logic [4:0] TAG_NO_RESPONSE = 5'h1E;
    localparam logic [4:0] TAG_INVALID = 5'h1F;

    // Rotation list
    localparam int unsigned ROT_DEPTH = 9;
    localparam int unsigned ROT_IDX_W = 4;
    localparam logic [3:0] ROT_DEPTH_IDX = 4'h9;

    // Interface update cycle, 58 ms at 50 MHz, exactly 2900000 cycles
    localparam int unsigned UPDATE_PERIOD_US = 58000;
    localparam int unsigned CLOCK_MHZ = 50;
    localparam int unsigned UPDATE_CYCLES_DEF = UPDATE_PERIOD_US * CLOCK_MHZ;

    // Value source of the current report
    typedef enum logic [1:0] {
        MODE_STATIC,
        MODE_REALTIME,
        MODE_AUTO,
        MODE_PACED
    } sfcx_mode_t;

    function automatic logic is_realtime(input logic [4:0] tag);
        return (tag == TAG_GROSS) || (tag == TAG_NET) || (tag == TAG_FINE_GROSS) ||
               (tag == TAG_FINE_NET) || (tag == TAG_RATE);
    endfunction

endpackage

// ---- hw/sfcx_rot_mem.sv ----
// Rotation list store: one write port, registered read.
// Models retained storage: contents are never cleared by any reset.
`timescale 1ns/1ps
module sfcx_rot_mem #(
    parameter int unsigned DEPTH = 9,
    parameter int unsigned IDX_W = 4,
    parameter int unsigned DATA_W = 5
) (
    input wire logic i_clock, // System clock
    input wire logic i_we, // Write enable
    input wire logic [IDX_W-1:0] i_waddr, // Write index
    input wire logic [DATA_W-1:0] i_wdata, // Write data
    input wire logic [IDX_W-1:0] i_raddr, // Read index
    output logic [DATA_W-1:0] o_rdata // Read data, one cycle late
);
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// ---- hw/sfcx_exchange.sv ----
// Float command exchange for one message slot of a weighing terminal.
// Assumes an AXI4-Lite master acting as controller, a weighing core that
// returns the value for o_value_tag one cycle later, and same-clock status.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module sfcx_exchange #(
    parameter int unsigned UPDATE_CYCLES = sfcx_pkg::UPDATE_CYCLES_DEF
) (
    input wire logic i_clock, // System clock, 50 MHz
    input wire logic i_resetn, // Warm reset, sync, active low
    input wire logic i_por_n, // Power-on reset of retained state, sync, active low
    input wire logic [7:0] i_awaddr, // AXI write address
    input wire logic i_awvalid, // AXI write address valid
    output logic o_awready, // AXI write address ready
    input wire logic [31:0] i_wdata, // AXI write data
    input wire logic [3:0] i_wstrb, // AXI write strobes
    input wire logic i_wvalid, // AXI write data valid
    output logic o_wready, // AXI write data ready
    output logic [1:0] o_bresp, // AXI write response
    output logic o_bvalid, // AXI write response valid
    input wire logic i_bready, // AXI write response ready
    input wire logic [7:0] i_araddr, // AXI read address
    input wire logic i_arvalid, // AXI read address valid
    output logic o_arready, // AXI read address ready
    output logic [31:0] o_rdata, // AXI read data
    output logic [1:0] o_rresp, // AXI read response
    output logic o_rvalid, // AXI read valid
    input wire logic i_rready, // AXI read ready
    output logic [4:0] o_value_tag, // Quantity requested from weighing core
    input wire logic [31:0] i_value_data, // Float value for o_value_tag
    output logic o_load_strobe, // Pulse: load operand into quantity
    output logic [4:0] o_load_tag, // Quantity to load
    output logic [31:0] o_load_value, // Float operand to load
    input wire logic [2:0] i_target, // Target comparison states
    input wire logic [1:0] i_comparator, // Comparator states
    input wire logic [1:0] i_script_flag, // Script flags
    input wire logic i_enter_key, // Enter key latched
    input wire logic [2:0] i_hw_input, // Hardware input pins, async
    input wire logic i_motion, // Scale in motion
    input wire logic i_net_mode, // Scale in net mode
    input wire logic i_power_up, // Power-up in progress
    input wire logic i_setup, // Setup in progress
    input wire logic i_over_capacity, // Scale over capacity
    input wire logic i_under_zero, // Scale under zero
    output logic [15:0] o_response_word, // Published command response word
    output logic [15:0] o_value_word_a, // Published float, bits 31:16
    output logic [15:0] o_value_word_b, // Published float, bits 15:0
    output logic [15:0] o_status_word, // Published scale status word
    output logic o_update // Pulse: slot words just published
);
    import sfcx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [15:0] cmd_word;
    logic [15:0] operand_a;
    logic [15:0] operand_b;

    assign o_awready = !aw_held && !o_bvalid;
    assign o_wready = !w_held && !o_bvalid;
    wire aw_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire wr_fire = aw_held && w_held && !o_bvalid;
    wire wr_cmd = wr_fire && (aw_addr == ADDR_COMMAND);
    wire wr_opa = wr_fire && (aw_addr == ADDR_OPERAND_A);
    wire wr_opb = wr_fire && (aw_addr == ADDR_OPERAND_B);
    wire wr_ok = (aw_addr == ADDR_COMMAND) || (aw_addr == ADDR_OPERAND_A) ||
                 (aw_addr == ADDR_OPERAND_B);

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= AXI_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Controller output words
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cmd_word <= CMD_NONE;
            operand_a <= 16'h0000;
            operand_b <= 16'h0000;
        end else begin
            if (wr_cmd) begin
                cmd_word <= merge16(cmd_word, w_data, w_strb);
            end
            if (wr_opa) begin
                operand_a <= merge16(operand_a, w_data, w_strb);
            end
            if (wr_opb) begin
                operand_b <= merge16(operand_b, w_data, w_strb);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    wire rd_known = (i_araddr == ADDR_RESPONSE) || (i_araddr == ADDR_VALUE_A) ||
                    (i_araddr == ADDR_VALUE_B) || (i_araddr == ADDR_STATUS) ||
                    (i_araddr == ADDR_COMMAND) || (i_araddr == ADDR_OPERAND_A) ||
                    (i_araddr == ADDR_OPERAND_B);
    wire [15:0] rd_word = (i_araddr == ADDR_RESPONSE) ? o_response_word :
                          (i_araddr == ADDR_VALUE_A) ? o_value_word_a :
                          (i_araddr == ADDR_VALUE_B) ? o_value_word_b :
                          (i_araddr == ADDR_STATUS) ? o_status_word :
                          (i_araddr == ADDR_COMMAND) ? cmd_word :
                          (i_araddr == ADDR_OPERAND_A) ? operand_a :
                          (i_araddr == ADDR_OPERAND_B) ? operand_b : 16'h0000;

    assign o_arready = !o_rvalid;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= AXI_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= {16'h0000, rd_word};
            o_rresp <= rd_known ? AXI_OKAY : AXI_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hardware input pins: three stages, change taken when last two agree
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_level;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_level <= 3'h0;
        end else begin
            pin_s1 <= i_hw_input;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 | pin_s3));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Update cycle timer: tick selects, publish one cycle later
    logic [31:0] upd_count;
    logic publish;
    wire tick = (upd_count == UPDATE_CYCLES - 1);

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            upd_count <= 32'h0000_0000;
            publish <= 1'b0;
        end else begin
            upd_count <= tick ? 32'h0000_0000 : upd_count + 32'h0000_0001;
            publish <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rotation list
    logic [3:0] rot_count;
    logic [3:0] rot_idx;
    logic [4:0] rot_rdata;
    wire [3:0] rot_idx_inc = rot_idx + 4'h1;
    wire [3:0] rot_next_idx = (rot_count == 4'h0 || rot_idx_inc >= rot_count) ? 4'h0 :
                              rot_idx_inc;
    wire [4:0] rot_next_tag = (rot_count == 4'h0) ? TAG_GROSS : rot_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    logic [15:0] last_cmd;
    logic [1:0] ack;
    logic integ;
    sfcx_mode_t mode;
    logic capture;
    logic [31:0] static_value;

    wire cmd_new = tick && (cmd_word != last_cmd);
    wire [4:0] cmd_tag = cmd_word[4:0];
    wire is_next = (cmd_word == CMD_NEXT_A) || (cmd_word == CMD_NEXT_B);
    wire is_auto = (cmd_word == CMD_AUTO);
    wire is_clear = (cmd_word == CMD_ROT_CLEAR);
    wire is_report = (cmd_word[15:5] == GRP_REPORT) && (cmd_tag < TAG_LAST_DATA);
    wire is_add = (cmd_word[15:5] == GRP_ADD) && is_realtime(cmd_tag);
    wire is_load = (cmd_word[15:5] == GRP_LOAD) && !is_realtime(cmd_tag) &&
                   (cmd_tag < TAG_LAST_DATA);
    wire rot_full = (rot_count == ROT_DEPTH_IDX);
    wire add_ok = cmd_new && is_add && !rot_full;
    wire advance = (cmd_new && (is_next || is_auto)) ||
                   (tick && !cmd_new && mode == MODE_AUTO);
    wire [1:0] next_ack = (cmd_word == CMD_NONE) ? ACK_IDLE :
                          (ack == ACK_LAST || ack == ACK_IDLE) ? ACK_FIRST :
                          ack + 2'h1;

    sfcx_rot_mem #(
        .DEPTH(ROT_DEPTH),
        .IDX_W(ROT_IDX_W),
        .DATA_W(TAG_W)
    ) u_rot_mem (
        .i_clock(i_clock),
        .i_we(add_ok),
        .i_waddr(rot_count),
        .i_wdata(cmd_tag),
        .i_raddr(rot_next_idx),
        .o_rdata(rot_rdata)
    );

    // Retained list length, cleared at power-on and by the clear command, not by warm reset
    always_ff @(posedge i_clock) begin
        if (!i_por_n) begin
            rot_count <= 4'h0;
        end else if (cmd_new && is_clear) begin
            rot_count <= 4'h0;
        end else if (add_ok) begin
            rot_count <= rot_count + 4'h1;
        end
    end

    // Command tracking, mode and tag selection at the tick
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            last_cmd <= CMD_NONE;
            ack <= ACK_IDLE;
            mode <= MODE_AUTO;
            o_value_tag <= TAG_GROSS;
            rot_idx <= 4'h0;
            capture <= 1'b0;
        end else if (tick) begin
            capture <= 1'b0;
            if (advance) begin
                rot_idx <= rot_next_idx;
                o_value_tag <= rot_next_tag;
            end
            if (cmd_new) begin
                last_cmd <= cmd_word;
                ack <= next_ack;
                if (is_next) begin
                    mode <= MODE_PACED;
                end else if (is_auto) begin
                    mode <= MODE_AUTO;
                end else if (is_report) begin
                    mode <= is_realtime(cmd_tag) ? MODE_REALTIME : MODE_STATIC;
                    capture <= !is_realtime(cmd_tag);
                    o_value_tag <= cmd_tag;
                end else if (cmd_word != CMD_NONE) begin
                    mode <= MODE_STATIC;
                    o_value_tag <= (is_clear || add_ok || is_load) ? TAG_NO_RESPONSE :
                                   TAG_INVALID;
                    if (is_clear) begin
                        rot_idx <= 4'h0;
                    end
                end
            end
        end
    end

    // Operand hand-off to the weighing core
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_load_strobe <= 1'b0;
            o_load_tag <= TAG_GROSS;
            o_load_value <= 32'h0000_0000;
        end else begin
            o_load_strobe <= cmd_new && is_load;
            if (cmd_new && is_load) begin
                o_load_tag <= cmd_tag;
                o_load_value <= {operand_a, operand_b};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot word publication
    wire no_value = (o_value_tag == TAG_NO_RESPONSE) || (o_value_tag == TAG_INVALID);
    wire [31:0] pub_value = no_value ? 32'h0000_0000 :
                            (mode != MODE_STATIC) ? i_value_data :
                            capture ? i_value_data : static_value;
    wire data_valid = !(i_power_up || i_setup || i_over_capacity || i_under_zero);
    wire [15:0] status_bits = {data_valid, !integ, i_net_mode, i_motion, pin_level,
                               i_enter_key, i_script_flag, 1'b1, i_target[2],
                               i_comparator[1], i_target[1], i_comparator[0],
                               i_target[0]};

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            integ <= 1'b0;
            static_value <= 32'h0000_0000;
            o_response_word <= 16'h0000;
            o_value_word_a <= 16'h0000;
            o_value_word_b <= 16'h0000;
            o_status_word <= 16'h0000;
            o_update <= 1'b0;
        end else begin
            o_update <= publish;
            if (publish) begin
                integ <= !integ;
                if (capture) begin
                    static_value <= i_value_data;
                end
                // All four words change on the same edge
                o_response_word <= {ack, !integ, o_value_tag, RESP_RESERVED};
                o_value_word_a <= pub_value[31:16];
                o_value_word_b <= pub_value[15:0];
                o_status_word <= status_bits;
            end
        end
    end

endmodule

// ---- dv/sfcx_exchange_monitor.sv ----
// Port checker of the float command exchange slot.
// Bound to sfcx_exchange; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module sfcx_exchange_monitor
import sfcx_pkg::*;
(
    input wire logic i_clock, // Clock
    input wire logic i_resetn, // Reset
    input wire logic i_awvalid, // Aw valid
    input wire logic o_awready, // Aw ready
    input wire logic i_wvalid, // W valid
    input wire logic o_wready, // W ready
    input wire logic o_bvalid, // B valid
    input wire logic [1:0] o_bresp, // B resp
    input wire logic i_arvalid, // Ar valid
    input wire logic o_arready, // Ar ready
    input wire logic o_rvalid, // R valid
    input wire logic i_rready, // R ready
    input wire logic [31:0] o_rdata, // R data
    input wire logic i_power_up, // Power-up
    input wire logic [15:0] o_response_word, // Word 1
    input wire logic [15:0] o_value_word_a, // Word 2
    input wire logic [15:0] o_value_word_b, // Word 3
    input wire logic [15:0] o_status_word, // Word 4
    input wire logic o_update // Publish
);
    logic prev_integ;
    wire [1:0] ack_now = o_response_word[15:14];
    always_ff @(posedge i_clock) begin
        if (!i_resetn) prev_integ <= 1'b0;
        else if (o_update) prev_integ <= o_response_word[13];
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    AST_RESERVED: assert property (o_response_word[7:0] == 8'h00)
        else $error("reserved response bits set");
    AST_INTEG_PAIR: assert property (o_response_word[13] == o_status_word[14])
        else $error("integrity bits disagree");
    AST_INTEG_TOGGLE: assert property (o_update |-> o_response_word[13] != prev_integ)
        else $error("integrity bit did not toggle");
    AST_ONE_BIT: assert property (o_update |-> o_status_word[5])
        else $error("status constant bit low");
    AST_TOGETHER: assert property (i_resetn && $changed({o_response_word,
        o_value_word_a, o_value_word_b, o_status_word}) |-> o_update)
        else $error("words changed unpublished");
    AST_ACK_STEP: assert property (($changed(ack_now) && $past(ack_now) != 2'h0
        && ack_now != 2'h0) |-> ack_now == (($past(ack_now) == 2'h3) ? 2'h1 : $past(ack_now) + 2'h1))
        else $error("acknowledge out of sequence");
    AST_DATA_VALID: assert property ((o_update && $past(i_power_up) && $past(i_power_up, 2)
        && $past(i_power_up, 3)) |-> !o_status_word[15]) else $error("data valid during power-up");
    AST_NO_VALUE: assert property ((o_update && o_response_word[12:8] >= TAG_NO_RESPONSE)
        |-> {o_value_word_a, o_value_word_b} == 32'h0) else $error("value sent with no-reply tag");
    AST_WRITE_ANSWER: assert property ((i_awvalid && o_awready && i_wvalid && o_wready)
        |=> ##1 o_bvalid) else $error("write answer late");
    AST_READ_ANSWER: assert property ((i_arvalid && o_arready) |=> o_rvalid)
        else $error("read answer late");
    AST_READ_HOLD: assert property ((o_rvalid && !i_rready) |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    cover property (o_update && ack_now == 2'h3);
    cover property (o_update && o_response_word[12:8] == TAG_INVALID);
    cover property (o_bvalid && o_bresp == AXI_SLVERR);
endmodule
bind sfcx_exchange sfcx_exchange_monitor u_mon (.*);

// ---- dv/sfcx_ctrl_model.sv ----
// Controller-side slot reader: judges integrity of each published slot.
// Assumes the slot words are settled while the publish pulse is high.
`timescale 1ns/1ps
module sfcx_ctrl_model (
    input wire logic i_clock, // Clock
    input wire logic i_update, // Publish pulse
    input wire logic [15:0] i_response_word, // Word 1
    input wire logic [15:0] i_status_word, // Word 4
    output int o_n_seen, // Slots accepted
    output int o_n_bad, // Slots refused
    output logic o_reissue // Would resend a command
);
    int run = 0;
    initial begin
        o_n_seen = 0;
        o_n_bad = 0;
        o_reissue = 1'b0;
    end
    always @(posedge i_clock) begin
        if (i_update) begin
            if (i_response_word[13] === i_status_word[14]) begin
                o_n_seen++;
                run = 0;
            end else begin
                o_n_bad++;
                run++;
                if (run >= 3) o_reissue = 1'b1;
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench of the float command exchange over AXI4-Lite.
// Short update cycle; value source echoes the requested tag.
`timescale 1ns/1ps
module tb_top;
import sfcx_pkg::*;
logic i_clock, i_resetn, i_por_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
logic [7:0] i_awaddr, i_araddr;
logic [31:0] i_wdata, o_rdata, o_load_value, i_value_data, rd;
logic [3:0] i_wstrb;
logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_load_strobe, o_update;
logic [1:0] o_bresp, o_rresp, rsp, i_comparator, i_script_flag;
logic [4:0] o_value_tag, o_load_tag, t1;
logic [2:0] i_target, i_hw_input;
logic i_enter_key, i_motion, i_net_mode, i_power_up, i_setup, i_over_capacity, i_under_zero;
logic [15:0] o_response_word, o_value_word_a, o_value_word_b, o_status_word, val_lo;
logic reissue, load_seen = 1'b0;
int n_mismatch = 0, n_checks = 0, cyc = 0, n_seen, n_bad, i;
assign i_value_data = {11'h000, o_value_tag, val_lo};
sfcx_exchange #(.UPDATE_CYCLES(10)) DUT (.*);
sfcx_ctrl_model CTRL (.i_clock(i_clock), .i_update(o_update), .i_response_word(o_response_word),
    .i_status_word(o_status_word), .o_n_seen(n_seen), .o_n_bad(n_bad), .o_reissue(reissue));
initial begin
    i_clock = 0;
    forever #10 i_clock = ~i_clock;
end
always @(posedge i_clock) begin
    cyc++;
    if (o_load_strobe === 1'b1) load_seen <= 1'b1;
    if (cyc == 20000) begin
        n_mismatch++;
        conclude();
    end
end
task conclude;
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1; tb = 0;
    while (!tb) begin
        @(negedge i_clock);
        ta = i_awvalid && o_awready; tw = i_wvalid && o_wready; tb = o_bvalid; rsp = o_bresp;
        @(posedge i_clock);
        if (ta) i_awvalid <= 0;
        if (tw) i_wvalid <= 0;
    end
    i_bready <= 0;
    @(posedge i_clock);
endtask
task axi_rd(input logic [7:0] a);
    logic ta, tr;
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1; tr = 0;
    while (!tr) begin
        @(negedge i_clock);
        ta = i_arvalid && o_arready; tr = o_rvalid; rd = o_rdata; rsp = o_rresp;
        @(posedge i_clock);
        if (ta) i_arvalid <= 0;
    end
    i_rready <= 0;
    @(posedge i_clock);
endtask
task wupd(input int n);
    repeat (n) begin
        do @(negedge i_clock); while (o_update !== 1'b1);
        @(posedge i_clock);
    end
endtask
task cmd(input logic [15:0] c);
    axi_wr(ADDR_COMMAND, {16'h0, c});
    wupd(2);
endtask
task exp_resp(input logic [1:0] ack, input logic [4:0] tag);
    axi_rd(ADDR_RESPONSE);
    chk(rd & 32'hFFFFDFFF, {16'h0, ack, 1'b0, tag, 8'h00});
endtask
task tag_pair(output logic [4:0] t);
    axi_rd(ADDR_RESPONSE);
    t = rd[12:8];
    chk({31'h0, t == TAG_NET || t == TAG_RATE}, 32'h1);
endtask
initial begin
    {i_resetn, i_por_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 0;
    {i_awaddr, i_araddr, i_wdata} = 0;
    i_wstrb = 4'hF; i_target = 3'h5; i_comparator = 2'h2; i_script_flag = 2'h1;
    i_hw_input = 3'h3; {i_enter_key, i_motion, i_net_mode} = 3'h6; val_lo = 16'h1234;
    {i_power_up, i_setup, i_over_capacity, i_under_zero} = 4'h0;
    repeat (4) @(posedge i_clock);
    i_resetn <= 1; i_por_n <= 1;
    axi_rd(ADDR_RESPONSE); chk(rd, 32'h0);
    axi_rd(8'h1C); chk({rd[31:2], rsp}, {30'h0, AXI_SLVERR});
    axi_wr(ADDR_STATUS, 32'hFFFF); chk({30'h0, rsp}, {30'h0, AXI_SLVERR});
    wupd(2); exp_resp(ACK_IDLE, TAG_GROSS);
    axi_rd(ADDR_VALUE_B); chk(rd, 32'h1234);
    axi_rd(ADDR_STATUS); chk(rd & 32'hBFFF, 32'h9779);
    for (i = 0; i < 4; i++) begin
        {i_power_up, i_setup, i_over_capacity, i_under_zero} <= 4'h8 >> i;
        wupd(2); axi_rd(ADDR_STATUS); chk({31'h0, rd[15]}, 32'h0);
    end
    {i_power_up, i_setup, i_over_capacity, i_under_zero} <= 4'h0;
    cmd(16'h0021); exp_resp(ACK_FIRST, TAG_NET);
    val_lo <= 16'h5A5A; wupd(2); axi_rd(ADDR_VALUE_B); chk(rd, 32'h5A5A);
    axi_rd(ADDR_VALUE_A); chk(rd, {27'h0, TAG_NET});
    cmd(16'h0022); exp_resp(2'h2, 5'h02);
    val_lo <= 16'h0F0F; wupd(2); axi_rd(ADDR_VALUE_B); chk(rd, 32'h5A5A);
    cmd(16'h0022); exp_resp(2'h2, 5'h02);
    axi_wr(ADDR_OPERAND_A, 32'h4120); axi_wr(ADDR_OPERAND_B, 32'h8000);
    cmd(16'h006D); exp_resp(ACK_LAST, TAG_NO_RESPONSE);
    chk(o_load_value, 32'h41208000); chk({27'h0, o_load_tag}, 32'hD);
    chk({31'h0, load_seen}, 32'h1);
    cmd(CMD_NONE); axi_rd(ADDR_RESPONSE); chk({30'h0, rd[15:14]}, 32'h0);
    cmd(CMD_ROT_CLEAR);
    for (i = 0; i < 10; i++) begin
        cmd({GRP_ADD, 4'h0, i[0]}); axi_rd(ADDR_RESPONSE);
        chk({27'h0, rd[12:8]}, {27'h0, (i < 9) ? TAG_NO_RESPONSE : TAG_INVALID});
    end
    cmd(CMD_ROT_CLEAR); cmd(16'h0041); cmd(16'h0046);
    cmd(CMD_NEXT_A); tag_pair(t1);
    cmd(CMD_NEXT_B); exp_resp(2'h1, (t1 == TAG_NET) ? TAG_RATE : TAG_NET);
    wupd(2); exp_resp(2'h1, (t1 == TAG_NET) ? TAG_RATE : TAG_NET);
    cmd(CMD_AUTO); tag_pair(t1);
    wupd(1); exp_resp(2'h2, (t1 == TAG_NET) ? TAG_RATE : TAG_NET);
    i_resetn <= 0; repeat (2) @(posedge i_clock); i_resetn <= 1;
    wupd(1); tag_pair(t1);
    wupd(1); exp_resp(ACK_IDLE, (t1 == TAG_NET) ? TAG_RATE : TAG_NET);
    chk(n_bad, 0); chk({31'h0, n_seen > 0}, 32'h1);
    chk({31'h0, reissue}, 32'h0);
    conclude();
end
endmodule
